// File: bench/i2cto_bus_model.sv
/*
 Far side of the two-wire bus: another party moving the clock and data lines.
 Assumes pulled-up lines, so the idle level is high and is driven as such.
*/
`timescale 1ns/1ns
module i2cto_bus_model (
    input wire clock_in,
    output logic scl_out,
    output logic sda_out
);
    initial begin
        scl_out = 1'b1;
        sda_out = 1'b1;
    end
    // Four quiet cycles first, longer than the pin synchroniser, so no edge is lost
    task drive(input logic c, input logic s);
        begin
            repeat (4) @(posedge clock_in);
            scl_out <= c;
            sda_out <= s;
        end
    endtask
endmodule

// File: bench/i2cto_top_sva.sv
/*
 Port checker for the time-out, prescaler and masked status block.
 Assumes the default register map and a sixteen-bit divide value.
*/
`timescale 1ns/1ns
`include "i2cto_consts.vh"
module i2cto_top_sva #(
    parameter AW = 8
) (
    input wire clock_in,
    input wire rstn_in,
    input wire [AW-1:0] reg_addr_in,
    input wire [31:0] reg_wdata_in,
    input wire reg_write_in,
    input wire reg_read_in,
    input wire [31:0] reg_rdata_out,
    input wire scl_in,
    input wire function_clock_tick_out,
    input wire bus_busy_out,
    input wire bus_event_timeout_flag_out,
    input wire clock_low_timeout_flag_out,
    input wire bus_event_timeout_irq_out,
    input wire clock_low_timeout_irq_out
);
    default clocking cb @(posedge clock_in); endclocking
    default disable iff (!rstn_in);
    reg [15:0] div_q;
    reg [15:0] gap_q;
    reg [1:0] set_q;
    // The first ticks after a divider write may be irregular, so they are skipped
    always @(posedge clock_in) begin
        if (!rstn_in) begin
            div_q <= 16'h0000;
            gap_q <= 16'h0000;
            set_q <= 2'h0;
        end else begin
            gap_q <= function_clock_tick_out ? 16'h0000 : gap_q + 16'h0001;
            if (reg_write_in && reg_addr_in == `I2CTO_OFF_DIVIDER) begin
                div_q <= reg_wdata_in[15:0];
                set_q <= 2'h0;
            end else if (function_clock_tick_out && set_q != 2'h2) begin
                set_q <= set_q + 2'h1;
            end
        end
    end
    a_tick_spacing: assert property (
        set_q == 2'h2 && function_clock_tick_out |-> gap_q == div_q)
        else $error("function clock tick spacing wrong");
    a_low_nibble_ones: assert property (
        $past(reg_read_in && reg_addr_in == `I2CTO_OFF_TIMEOUT)
        |-> reg_rdata_out[3:0] == 4'hf)
        else $error("limit low nibble not ones");
    a_stat_reserved: assert property (
        $past(reg_read_in && reg_addr_in == `I2CTO_OFF_MSTAT)
        |-> (reg_rdata_out & ~`I2CTO_STAT_MASK) == 32'h0)
        else $error("status reserved bit set");
    a_event_irq_gate: assert property (
        bus_event_timeout_irq_out |->
        bus_event_timeout_flag_out || $past(bus_event_timeout_flag_out))
        else $error("event irq without flag");
    a_low_irq_gate: assert property (
        clock_low_timeout_irq_out |->
        clock_low_timeout_flag_out || $past(clock_low_timeout_flag_out))
        else $error("clock-low irq without flag");
    a_event_when_busy: assert property (
        $rose(bus_event_timeout_flag_out) |-> $past(bus_busy_out))
        else $error("event flag set while idle");
    a_low_when_busy: assert property (
        $rose(clock_low_timeout_flag_out) |-> $past(bus_busy_out))
        else $error("clock-low flag set while idle");
    a_low_held_low: assert property (
        $rose(clock_low_timeout_flag_out) |-> !$past(scl_in, 6) && !$past(scl_in, 16))
        else $error("clock-low flag with clock high");
    a_event_quiet: assert property (
        $rose(bus_event_timeout_flag_out) |-> $past(scl_in, 6) == $past(scl_in, 16))
        else $error("event flag soon after edge");
endmodule
bind i2cto_top i2cto_top_sva #(.AW(AW)) u_sva (.clock_in(clock_in), .rstn_in(rstn_in),
    .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in), .reg_write_in(reg_write_in),
    .reg_read_in(reg_read_in), .reg_rdata_out(reg_rdata_out), .scl_in(scl_in),
    .function_clock_tick_out(function_clock_tick_out), .bus_busy_out(bus_busy_out),
    .bus_event_timeout_flag_out(bus_event_timeout_flag_out),
    .clock_low_timeout_flag_out(clock_low_timeout_flag_out),
    .bus_event_timeout_irq_out(bus_event_timeout_irq_out),
    .clock_low_timeout_irq_out(clock_low_timeout_irq_out));

// File: bench/i2cto_top_tb.sv
/*
 Self-checking bench: register map, masked status and both bus time-outs.
 Assumes the bus model on the pins and the bound port checker.
*/
`timescale 1ns/1ns
`include "i2cto_consts.vh"
module i2cto_top_tb;
    logic clock_in = 1'b0;
    logic rstn_in = 1'b0;
    logic [7:0] reg_addr_in = 8'h00;
    logic [31:0] reg_wdata_in = 32'h0;
    logic reg_write_in = 1'b0;
    logic reg_read_in = 1'b0;
    logic [3:0] stat_in = 4'h1;
    logic [31:0] seed = 32'hc309;
    logic [31:0] v;
    logic [31:0] r;
    logic [31:0] e;
    wire [31:0] reg_rdata_out;
    wire scl;
    wire sda;
    wire busy;
    wire ev_flag;
    wire cl_flag;
    wire ev_irq;
    wire cl_irq;
    integer fail_count = 0;
    integer checks = 0;
    integer cyc = 0;
    integer n;
    integer lim;
    integer i;

    always #2 clock_in = ~clock_in;

    i2cto_bus_model i_bus (.clock_in(clock_in), .scl_out(scl), .sda_out(sda));
    i2cto_top i_dut (.clock_in(clock_in), .rstn_in(rstn_in), .reg_addr_in(reg_addr_in),
        .reg_wdata_in(reg_wdata_in), .reg_write_in(reg_write_in), .reg_read_in(reg_read_in),
        .reg_rdata_out(reg_rdata_out), .scl_in(scl), .sda_in(sda),
        .master_pending_in(stat_in[0]), .master_arbitration_lost_in(stat_in[1]),
        .master_start_stop_error_in(stat_in[2]), .slave_pending_in(stat_in[3]),
        .function_clock_tick_out(), .bus_busy_out(busy), .bus_event_timeout_flag_out(ev_flag),
        .clock_low_timeout_flag_out(cl_flag), .bus_event_timeout_irq_out(ev_irq),
        .clock_low_timeout_irq_out(cl_irq));

    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    function automatic logic [31:0] exp_stat(input logic [3:0] s, input logic [31:0] en);
        return {23'h0, s[3], 1'b0, s[2], 1'b0, s[1], 3'h0, s[0]} & en & `I2CTO_STAT_MASK;
    endfunction
    task wrap_up;
        $display("checks %0d mismatches %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    task check(input string nm, input logic [31:0] x, input logic [31:0] g);
        checks = checks + 1;
        if (g !== x) begin
            fail_count = fail_count + 1;
            $display("MISMATCH %s expected %h seen %h", nm, x, g);
        end
    endtask
    task reg_wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clock_in);
        reg_addr_in <= a;
        reg_wdata_in <= d;
        reg_write_in <= 1'b1;
        @(posedge clock_in);
        reg_write_in <= 1'b0;
    endtask
    task reg_rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge clock_in);
        reg_addr_in <= a;
        reg_read_in <= 1'b1;
        @(posedge clock_in);
        reg_read_in <= 1'b0;
        #1 d = reg_rdata_out;
    endtask
    task tmo_case(input logic [11:0] f, input logic [15:0] d, input logic low, input logic st,
        input logic [1:0] en, input logic [1:0] tm);
        logic [1:0] fl;
        logic ok;
        fl = {st & low & tm[1], st & tm[0]};
        lim = (f + 1) * 16 * (d + 1);
        reg_wr(`I2CTO_OFF_TOEN, 32'h0);
        reg_wr(`I2CTO_OFF_TIMEOUT, {16'h0, f, 4'h0});
        reg_wr(`I2CTO_OFF_DIVIDER, {16'h0, d});
        reg_wr(`I2CTO_OFF_FLAGS, 32'h03000000);
        reg_wr(`I2CTO_OFF_INTEN, {6'h0, en, 24'h1});
        reg_wr(`I2CTO_OFF_TOEN, {30'h0, tm});
        #1 check("cleared", 32'h0, {30'h0, cl_flag, ev_flag});
        if (st) i_bus.drive(1'b1, 1'b0);
        if (low) i_bus.drive(1'b0, ~st);
        n = 0;
        while (ev_flag !== 1'b1 && n < lim + 40) begin
            @(posedge clock_in);
            #1 n = n + 1;
        end
        ok = (n >= lim) && (n <= lim + 8 + d);
        check("gap", {31'h0, fl[0]}, {31'h0, ok});
        repeat (3) @(posedge clock_in);
        #1 check("low", {31'h0, fl[1]}, {31'h0, cl_flag});
        check("busy", {31'h0, st}, {31'h0, busy});
        check("irq", {30'h0, en & fl}, {30'h0, cl_irq, ev_irq});
        reg_rd(`I2CTO_OFF_MSTAT, v);
        check("stat", {30'h0, en & fl}, {30'h0, v[25:24]});
        reg_rd(`I2CTO_OFF_FLAGS, v);
        check("flags", {30'h0, fl}, {30'h0, v[25:24]});
        if (st) i_bus.drive(1'b1, 1'b0);
        i_bus.drive(1'b1, 1'b1);
        repeat (8) @(posedge clock_in);
        #1 check("idle", 32'h0, {31'h0, busy});
        $display("time-out case f=%0h d=%0h low=%0b start=%0b done", f, d, low, st);
    endtask

    always @(posedge clock_in) begin
        cyc <= cyc + 1;
        if (cyc == 8000) begin
            fail_count = fail_count + 1;
            wrap_up;
        end
    end

    initial begin
        repeat (2) @(posedge clock_in);
        rstn_in <= 1'b1;
        reg_rd(`I2CTO_OFF_TIMEOUT, v);
        check("limit", 32'hffff, {16'h0, v[15:0]});
        reg_rd(`I2CTO_OFF_DIVIDER, v);
        check("div", 32'h0, {16'h0, v[15:0]});
        reg_rd(`I2CTO_OFF_MSTAT, v);
        check("stat", 32'h1, v);
        reg_rd(8'h08, v);
        check("unmapped", 32'h0, v);
        $display("reset values done");
        for (i = 0; i < 4; i = i + 1) begin
            r = xs() & 32'hffff;
            reg_wr(`I2CTO_OFF_TIMEOUT, r);
            reg_rd(`I2CTO_OFF_TIMEOUT, v);
            check("limit", {16'h0, r[15:4], 4'hf}, {16'h0, v[15:0]});
            reg_wr(`I2CTO_OFF_DIVIDER, r);
            reg_rd(`I2CTO_OFF_DIVIDER, v);
            check("div", r, {16'h0, v[15:0]});
        end
        for (i = 0; i < 16; i = i + 1) begin
            r = xs();
            e = xs();
            stat_in <= r[3:0];
            reg_wr(`I2CTO_OFF_INTEN, e);
            reg_rd(`I2CTO_OFF_MSTAT, v);
            check("stat", exp_stat(r[3:0], e), v);
        end
        // Status is a view only: a write there must leave nothing behind
        reg_wr(`I2CTO_OFF_MSTAT, 32'hffffffff);
        reg_rd(`I2CTO_OFF_MSTAT, v);
        check("stat_ro", exp_stat(r[3:0], e), v);
        $display("register map done");
        e = xs();
        tmo_case(12'h0, 16'h0, 1'b0, 1'b1, 2'b11, 2'b11);
        tmo_case({9'h0, e[4:2]}, {14'h0, e[6:5]}, 1'b1, 1'b1, e[1:0], 2'b11);
        tmo_case(12'h1, 16'h1, 1'b1, 1'b1, 2'b00, 2'b10);
        tmo_case(12'h0, 16'h0, 1'b1, 1'b0, 2'b11, 2'b11);
        wrap_up;
    end
endmodule

// File: rtl/i2cto_consts.vh
/*
 Constants of the two-wire bus time-out, prescaler and masked status block.
 Assumes inclusion by bare name from the design files under rtl/.
*/
`ifndef I2CTO_CONSTS_VH
`define I2CTO_CONSTS_VH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define I2CTO_OFF_TIMEOUT 8'h10
`define I2CTO_OFF_DIVIDER 8'h14
`define I2CTO_OFF_MSTAT 8'h18
`define I2CTO_OFF_INTEN 8'h1c
`define I2CTO_OFF_FLAGS 8'h30
`define I2CTO_OFF_TOEN 8'h34

// ----------------------------------------------------------------
// Field positions and reset values
// ----------------------------------------------------------------
`define I2CTO_FIXED_NIBBLE 4'hf
`define I2CTO_TO_RST 12'hfff
`define I2CTO_DIV_RST 16'h0000
`define I2CTO_BIT_MPEND 0
`define I2CTO_BIT_MARB 4
`define I2CTO_BIT_MSSERR 6
`define I2CTO_BIT_SPEND 8
`define I2CTO_BIT_EVTO 24
`define I2CTO_BIT_SCLTO 25
`define I2CTO_STAT_MASK 32'h03000151
`define I2CTO_INTEN_RST 32'h00000001
`define I2CTO_TOEN_RST 2'h3

`endif

// File: rtl/i2cto_function_clock_divider.v
/*
 Prescaler producing a one-cycle function clock tick.
 Assumes a divide value that is stable or changes at any time; a new value
 is compared at once, so one below the running count wraps it at once.
*/
`timescale 1ns/1ns
module i2cto_prescaler #(
    parameter WIDTH = 16
) (
    input wire clock_in,
    input wire rstn_in,
    input wire [WIDTH-1:0] divide_value_in,
    output wire tick_out
);

    reg [WIDTH-1:0] cnt_q;
    reg [WIDTH-1:0] cnt_d;
    wire wrap;

    // ----------------------------------------------------------------
    // Divide by value plus one
    // ----------------------------------------------------------------
    assign wrap = (cnt_q >= divide_value_in);

    always @* begin
        if (wrap) begin
            cnt_d = {WIDTH{1'b0}};
        end else begin
            cnt_d = cnt_q + {{(WIDTH-1){1'b0}}, 1'b1};
        end
    end

    always @(posedge clock_in) begin
        if (!rstn_in) begin
            cnt_q <= {WIDTH{1'b0}};
        end else begin
            cnt_q <= cnt_d;
        end
    end

    // Zero divide value gives a tick every cycle
    assign tick_out = wrap;

endmodule

// File: rtl/i2cto_monitor.v
/*
 One time-out monitor: counts function clock ticks since the last restart.
 Assumes restart and active are on the same clock as the tick.
*/
`timescale 1ns/1ns
module i2cto_monitor #(
    parameter WIDTH = 16
) (
    input wire clock_in,
    input wire rstn_in,
    input wire tick_in,
    input wire active_in,
    input wire restart_in,
    input wire [WIDTH-1:0] limit_in,
    output wire expire_out
);

    reg [WIDTH-1:0] cnt_q;
    reg [WIDTH-1:0] cnt_d;
    wire at_limit;

    // ----------------------------------------------------------------
    // Count and compare
    // ----------------------------------------------------------------
    assign at_limit = (cnt_q >= limit_in);

    always @* begin
        cnt_d = cnt_q;
        if (!active_in || restart_in) begin
            cnt_d = {WIDTH{1'b0}};
        end else if (tick_in && !at_limit) begin
            cnt_d = cnt_q + {{(WIDTH-1){1'b0}}, 1'b1};
        end
    end

    always @(posedge clock_in) begin
        if (!rstn_in) begin
            cnt_q <= {WIDTH{1'b0}};
        end else begin
            cnt_q <= cnt_d;
        end
    end

    // Limit L fires on tick L+1, so a limit of 15 is sixteen ticks
    assign expire_out = active_in && !restart_in && tick_in && at_limit;

endmodule

// File: rtl/i2cto_top.v
/*
 Two-wire bus support logic: function clock prescaler, bus-event and
 clock-low time-out monitors, raw flags and the masked status view, all
 behind a simple strobe register port.
 Assumes scl_in and sda_in come straight from the pins (asynchronous) and
 the protocol engine status inputs come from logic on clock_in.
*/
`timescale 1ns/1ns
`include "i2cto_consts.vh"
module i2cto_top #(
    parameter AW = 8,
    parameter DIVW = 16
) (
    input wire clock_in,
    input wire rstn_in,
    input wire [AW-1:0] reg_addr_in,
    input wire [31:0] reg_wdata_in,
    input wire reg_write_in,
    input wire reg_read_in,
    output reg [31:0] reg_rdata_out,
    input wire scl_in,
    input wire sda_in,
    input wire master_pending_in,
    input wire master_arbitration_lost_in,
    input wire master_start_stop_error_in,
    input wire slave_pending_in,
    output reg function_clock_tick_out,
    output reg bus_busy_out,
    output reg bus_event_timeout_flag_out,
    output reg clock_low_timeout_flag_out,
    output reg bus_event_timeout_irq_out,
    output reg clock_low_timeout_irq_out
);

    // ----------------------------------------------------------------
    // Decode helper
    // ----------------------------------------------------------------
    function hit;
        input [AW-1:0] addr;
        input [7:0] offset;
        begin
            hit = (addr == offset[AW-1:0]);
        end
    endfunction

    // ----------------------------------------------------------------
    // Pin synchronisers
    // ----------------------------------------------------------------
    reg scl_meta_q;
    reg scl_sync_q;
    reg scl_prev_q;
    reg sda_meta_q;
    reg sda_sync_q;
    reg sda_prev_q;

    always @(posedge clock_in) begin
        if (!rstn_in) begin
            scl_meta_q <= 1'b1;
            scl_sync_q <= 1'b1;
            scl_prev_q <= 1'b1;
            sda_meta_q <= 1'b1;
            sda_sync_q <= 1'b1;
            sda_prev_q <= 1'b1;
        end else begin
            scl_meta_q <= scl_in;
            scl_sync_q <= scl_meta_q;
            scl_prev_q <= scl_sync_q;
            sda_meta_q <= sda_in;
            sda_sync_q <= sda_meta_q;
            sda_prev_q <= sda_sync_q;
        end
    end

    // ----------------------------------------------------------------
    // Bus events and busy state
    // ----------------------------------------------------------------
    wire scl_rise;
    wire scl_fall;
    wire start_cond;
    wire stop_cond;
    wire any_event;
    reg busy_q;
    reg busy_d;

    assign scl_rise = scl_sync_q && !scl_prev_q;
    assign scl_fall = !scl_sync_q && scl_prev_q;
    // Data moving while the clock stays high marks start or stop
    assign start_cond = scl_sync_q && scl_prev_q && !sda_sync_q && sda_prev_q;
    assign stop_cond = scl_sync_q && scl_prev_q && sda_sync_q && !sda_prev_q;
    assign any_event = start_cond || stop_cond || scl_rise || scl_fall;

    always @* begin
        busy_d = busy_q;
        if (start_cond) begin
            busy_d = 1'b1;
        end else if (stop_cond) begin
            busy_d = 1'b0;
        end
    end

    always @(posedge clock_in) begin
        if (!rstn_in) begin
            busy_q <= 1'b0;
        end else begin
            busy_q <= busy_d;
        end
    end

    // ----------------------------------------------------------------
    // Registers written by software
    // ----------------------------------------------------------------
    reg [11:0] to_field_q;
    reg [DIVW-1:0] div_q;
    reg [31:0] inten_q;
    reg [1:0] toen_q;
    wire wr_timeout;
    wire wr_divider;
    wire wr_inten;
    wire wr_flags;
    wire wr_toen;

    assign wr_timeout = reg_write_in && hit(reg_addr_in, `I2CTO_OFF_TIMEOUT);
    assign wr_divider = reg_write_in && hit(reg_addr_in, `I2CTO_OFF_DIVIDER);
    assign wr_inten = reg_write_in && hit(reg_addr_in, `I2CTO_OFF_INTEN);
    assign wr_flags = reg_write_in && hit(reg_addr_in, `I2CTO_OFF_FLAGS);
    assign wr_toen = reg_write_in && hit(reg_addr_in, `I2CTO_OFF_TOEN);

    always @(posedge clock_in) begin
        if (!rstn_in) begin
            to_field_q <= `I2CTO_TO_RST;
            div_q <= `I2CTO_DIV_RST;
            inten_q <= `I2CTO_INTEN_RST;
            toen_q <= `I2CTO_TOEN_RST;
        end else begin
            if (wr_timeout) begin
                // Bits 3..0 are not stored; upper half is dropped
                to_field_q <= reg_wdata_in[15:4];
            end
            if (wr_divider) begin
                div_q <= reg_wdata_in[DIVW-1:0];
            end
            if (wr_inten) begin
                inten_q <= reg_wdata_in & `I2CTO_STAT_MASK;
            end
            if (wr_toen) begin
                // Each monitor has its own enable: bit 0 bus event, bit 1 clock low
                toen_q <= reg_wdata_in[1:0];
            end
        end
    end

    // ----------------------------------------------------------------
    // Function clock and time-out monitors
    // ----------------------------------------------------------------
    wire fclk_tick;
    wire [15:0] limit;
    wire ev_active;
    wire scl_active;
    wire ev_expire;
    wire scl_expire;

    // A divide value below the running count wraps at once,
    // so one short function clock period follows such a write
    i2cto_prescaler #(
        .WIDTH(DIVW)
    ) u_prescaler (
        .clock_in(clock_in),
        .rstn_in(rstn_in),
        .divide_value_in(div_q),
        .tick_out(fclk_tick)
    );

    // Fixed low nibble gives a sixteen-tick minimum and step
    assign limit = {to_field_q, `I2CTO_FIXED_NIBBLE};

    // Stop ends busy, so the counter is held cleared from the cycle after
    assign ev_active = busy_q && toen_q[0];
    // Only low time counts; a high clock holds the count cleared
    assign scl_active = busy_q && toen_q[1] && !scl_sync_q;

    i2cto_monitor #(
        .WIDTH(16)
    ) u_event_mon (
        .clock_in(clock_in),
        .rstn_in(rstn_in),
        .tick_in(fclk_tick),
        .active_in(ev_active),
        .restart_in(any_event),
        .limit_in(limit),
        .expire_out(ev_expire)
    );

    i2cto_monitor #(
        .WIDTH(16)
    ) u_scl_mon (
        .clock_in(clock_in),
        .rstn_in(rstn_in),
        .tick_in(fclk_tick),
        .active_in(scl_active),
        .restart_in(scl_fall),
        .limit_in(limit),
        .expire_out(scl_expire)
    );

    // ----------------------------------------------------------------
    // Sticky time-out flags
    // ----------------------------------------------------------------
    reg ev_flag_q;
    reg scl_flag_q;
    wire ev_clr;
    wire scl_clr;

    // Software clears a flag by writing one to its raw flag position
    assign ev_clr = wr_flags && reg_wdata_in[`I2CTO_BIT_EVTO];
    assign scl_clr = wr_flags && reg_wdata_in[`I2CTO_BIT_SCLTO];

    always @(posedge clock_in) begin
        if (!rstn_in) begin
            ev_flag_q <= 1'b0;
            scl_flag_q <= 1'b0;
        end else begin
            // A new expiry beats a clear in the same cycle
            ev_flag_q <= (ev_flag_q && !ev_clr) || ev_expire;
            scl_flag_q <= (scl_flag_q && !scl_clr) || scl_expire;
        end
    end

    // ----------------------------------------------------------------
    // Raw and masked status
    // ----------------------------------------------------------------
    reg [31:0] raw_stat;
    wire [31:0] masked_stat;

    always @* begin
        raw_stat = 32'h00000000;
        raw_stat[`I2CTO_BIT_MPEND] = master_pending_in;
        raw_stat[`I2CTO_BIT_MARB] = master_arbitration_lost_in;
        raw_stat[`I2CTO_BIT_MSSERR] = master_start_stop_error_in;
        raw_stat[`I2CTO_BIT_SPEND] = slave_pending_in;
        raw_stat[`I2CTO_BIT_EVTO] = ev_flag_q;
        raw_stat[`I2CTO_BIT_SCLTO] = scl_flag_q;
    end

    // Reserved positions are masked out and read as zero
    assign masked_stat = raw_stat & inten_q & `I2CTO_STAT_MASK;

    // ----------------------------------------------------------------
    // Read port
    // ----------------------------------------------------------------
    reg [31:0] rdata_d;

    always @* begin
        rdata_d = 32'h00000000;
        // Upper half reads as zero, though software may not rely on it
        if (hit(reg_addr_in, `I2CTO_OFF_TIMEOUT)) begin
            rdata_d = {16'h0000, to_field_q, `I2CTO_FIXED_NIBBLE};
        end else if (hit(reg_addr_in, `I2CTO_OFF_DIVIDER)) begin
            rdata_d[DIVW-1:0] = div_q;
        end else if (hit(reg_addr_in, `I2CTO_OFF_MSTAT)) begin
            rdata_d = masked_stat;
        end else if (hit(reg_addr_in, `I2CTO_OFF_INTEN)) begin
            rdata_d = inten_q;
        end else if (hit(reg_addr_in, `I2CTO_OFF_FLAGS)) begin
            rdata_d = raw_stat;
        end else if (hit(reg_addr_in, `I2CTO_OFF_TOEN)) begin
            rdata_d = {30'h0, toen_q};
        end
    end

    // Data stand only in the cycle after the read strobe
    always @(posedge clock_in) begin
        if (!rstn_in) begin
            reg_rdata_out <= 32'h00000000;
        end else if (reg_read_in) begin
            reg_rdata_out <= rdata_d;
        end else begin
            reg_rdata_out <= 32'h00000000;
        end
    end

    // ----------------------------------------------------------------
    // Registered outputs
    // ----------------------------------------------------------------
    always @(posedge clock_in) begin
        if (!rstn_in) begin
            function_clock_tick_out <= 1'b0;
            bus_busy_out <= 1'b0;
            bus_event_timeout_flag_out <= 1'b0;
            clock_low_timeout_flag_out <= 1'b0;
            bus_event_timeout_irq_out <= 1'b0;
            clock_low_timeout_irq_out <= 1'b0;
        end else begin
            function_clock_tick_out <= fclk_tick;
            bus_busy_out <= busy_q;
            bus_event_timeout_flag_out <= ev_flag_q;
            clock_low_timeout_flag_out <= scl_flag_q;
            bus_event_timeout_irq_out <= masked_stat[`I2CTO_BIT_EVTO];
            clock_low_timeout_irq_out <= masked_stat[`I2CTO_BIT_SCLTO];
        end
    end

endmodule
